// File: logic/dtp_pkg.sv
// dtp_pkg: constants, types and helpers of the deadtime and polarity block
// assumes a 100 MHz clock and a 32-bit apb slave port
package dtp_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_DTCFG  = 8'h00;
    localparam logic [7:0] ADDR_POLCFG = 8'h04;
    localparam logic [7:0] ADDR_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_PHST   = 8'h0C;
    localparam logic [7:0] ADDR_STAT   = 8'h10;
    // ----------------------------------------
    // reset values and field positions
    // ----------------------------------------
    localparam logic [7:0] DTCFG_RST = 8'hFF;
    localparam logic [7:0] POL_RST   = 8'h3F;
    localparam logic [8:0] CTRL_RST  = 9'h000;
    localparam logic [5:0] PHST_RST  = 6'h00;
    localparam int PCN_BIT  = 7;
    localparam int DTE_BIT  = 6;
    localparam int ZVD_BIT  = 7;
    localparam int REO_BIT  = 6;
    localparam int CKE_BIT  = 0;
    localparam int MOE_BIT  = 1;
    localparam int DAC_BIT  = 2;
    localparam int OS0_BIT  = 3;
    localparam int HFE_LSB  = 4;
    localparam int HFRQ_LSB = 6;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DT_STEP_NS    = 125;
    localparam logic [9:0] DT_STEP_CYC =
        10'((DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ----------------------------------------
    // types and helpers
    // ----------------------------------------
    typedef enum logic [0:0] {DTP_IDLE = 1'b0, DTP_RESP = 1'b1} dtp_apb_t;
    function automatic logic [7:0] dtp_merge(input logic [7:0] old,
        input logic [7:0] nw, input logic [7:0] mask);
        return (old & ~mask) | (nw & mask);
    endfunction
    function automatic logic dtp_pin(input logic pol, input logic act);
        return ~(pol ^ act);
    endfunction
endpackage

// File: logic/dtp_out_if.sv
// dtp_out_if: carries switch requests from the core to deadtime and stage
// assumes all parties on one clock
`timescale 1ns/1ps
interface dtp_out_if;
    logic [5:0] act;
    logic       dtOn;
    logic [9:0] dtCyc;
    logic [5:0] gated;
    logic [5:0] pol;
    modport core  (output act, dtOn, dtCyc, pol, input gated);
    modport dtgen (input act, dtOn, dtCyc, output gated);
    modport stage (input gated, pol);
endinterface

// File: logic/dtp_deadtime.sv
// dtp_deadtime: delays each rising switch request by the deadtime
// assumes requests come from logic on the same clock
`timescale 1ns/1ps
module dtp_deadtime (
    input wire logic  clk,
    input wire logic  srst,
    dtp_out_if.dtgen  bus
);
    import dtp_pkg::*;
    logic [9:0] cnt [6];
    // ----------------------------------------
    // per switch delay counters
    // ----------------------------------------
    // rising edge delay
    always_ff @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            if (srst || !bus.act[i]) begin
                cnt[i] <= 10'h000;
                bus.gated[i] <= 1'b0;
            end else if (!bus.dtOn || cnt[i] >= bus.dtCyc) begin
                bus.gated[i] <= 1'b1;
            end else begin
                cnt[i] <= cnt[i] + 10'h001;
            end
        end
    end
endmodule // dtp_deadtime

// File: logic/dtp_stage.sv
// dtp_stage: applies output polarity and drives the motor pins
// assumes gated requests are already zero while outputs are disabled
`timescale 1ns/1ps
module dtp_stage (
    input wire logic  clk,
    input wire logic  srst,
    dtp_out_if.stage  bus,
    output logic [5:0] motorOutPins
);
    import dtp_pkg::*;
    logic [5:0] next_pins;
    // ----------------------------------------
    // polarity mapping
    // ----------------------------------------
    // pin level table
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            next_pins[i] = dtp_pin(bus.pol[i], bus.gated[i]);
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            motorOutPins <= 6'h00;
        end else begin
            motorOutPins <= next_pins;
        end
    end
endmodule // dtp_stage

// File: logic/dtp_top.sv
// dtp_top: deadtime and output polarity stage of a motor pwm unit
// assumes pwm and commutation inputs from logic on clk; apb master on clk
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
module dtp_top (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pwmU,
    input  wire logic        pwmV,
    input  wire logic        pwmW,
    input  wire logic        commEvent,
    output logic [2:0]       chanMgrPwm,
    output logic [5:0]       motorOutPins,
    output logic             motorOutEn,
    output logic             edgeRelationSel,
    output logic             bemfChannelSel
);
    import dtp_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    dtp_out_if  outBus ();
    dtp_apb_t   apbState;
    dtp_apb_t   next_apbState;
    logic [7:0] deadtimeConfig;
    logic [7:0] outputPolarityConfig;
    logic [8:0] ctrlReg;
    logic [5:0] phaseStatePre;
    logic [5:0] outputState;
    logic       dtLocked;
    logic       polLocked;
    logic [9:0] chopCnt;
    logic [2:0] next_chanMgrPwm;

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    wire        channelCountSel   = deadtimeConfig[PCN_BIT];
    wire        deadtimeEnable    = deadtimeConfig[DTE_BIT];
    wire [5:0]  deadtimeSetting   = deadtimeConfig[5:0];
    wire [5:0]  outputPolarity    = outputPolarityConfig[5:0];
    wire        clockEnable       = ctrlReg[CKE_BIT];
    wire        masterOutputEnable = ctrlReg[MOE_BIT];
    wire        directAccess      = ctrlReg[DAC_BIT];
    wire        pwmApplicationSel = ctrlReg[OS0_BIT];
    wire [1:0]  chopperEnable     = ctrlReg[HFE_LSB +: 2];
    wire [2:0]  chopperFrequency  = ctrlReg[HFRQ_LSB +: 3];

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire access  = psel & penable;
    wire commit  = access & pready;
    wire hitDt   = (paddr == ADDR_DTCFG);
    wire hitPol  = (paddr == ADDR_POLCFG);
    wire hitCtrl = (paddr == ADDR_CTRL);
    wire hitPh   = (paddr == ADDR_PHST);
    wire hitStat = (paddr == ADDR_STAT);
    wire mapped  = hitDt | hitPol | hitCtrl | hitPh | hitStat;
    wire wrDt    = commit & pwrite & hitDt;
    wire wrPol   = commit & pwrite & hitPol;
    wire wrCtrl  = commit & pwrite & hitCtrl;
    wire wrPh    = commit & pwrite & hitPh;
    wire [7:0] wByte = pwdata[7:0];

    // ----------------------------------------
    // write-once masks
    // ----------------------------------------
    // enable write-once under pcn
    wire dteFree = ~channelCountSel | ~dtLocked;
    wire [7:0] dtMask  = {1'b1, dteFree, {6{~dtLocked}}};
    wire [7:0] polMask = {2'b11, {6{~polLocked}}};
    wire [7:0] next_dtCfg  = dtp_merge(deadtimeConfig, wByte, dtMask);
    wire [7:0] next_polCfg = dtp_merge(outputPolarityConfig, wByte, polMask);

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [31:0] statWord = {23'h000000, motorOutEn, polLocked, dtLocked,
                            motorOutPins};
    wire [31:0] rdMux =
        hitDt   ? {24'h000000, deadtimeConfig} :
        hitPol  ? {24'h000000, outputPolarityConfig} :
        hitCtrl ? {23'h000000, ctrlReg} :
        hitPh   ? {26'h0000000, outputState} :
        hitStat ? statWord : 32'h00000000;

    // ----------------------------------------
    // apb handshake
    // ----------------------------------------
    always_comb begin
        case (apbState)
            DTP_IDLE: next_apbState = access ? DTP_RESP : DTP_IDLE;
            DTP_RESP: next_apbState = DTP_IDLE;
            default:  next_apbState = DTP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            apbState <= DTP_IDLE;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h00000000;
        end else begin
            apbState <= next_apbState;
            pready   <= (next_apbState == DTP_RESP);
            pslverr  <= (next_apbState == DTP_RESP) & ~mapped;
            prdata   <= (next_apbState == DTP_RESP) ? rdMux : 32'h00000000;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    // reset values
    always_ff @(posedge clk) begin
        if (srst) begin
            deadtimeConfig       <= DTCFG_RST;
            outputPolarityConfig <= POL_RST;
            ctrlReg              <= CTRL_RST;
        end else begin
            if (wrDt) deadtimeConfig <= next_dtCfg;
            if (wrPol) outputPolarityConfig <= next_polCfg;
            if (wrCtrl) ctrlReg <= pwdata[8:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dtLocked  <= 1'b0;
            polLocked <= 1'b0;
        end else begin
            dtLocked  <= dtLocked | wrDt;
            polLocked <= polLocked | wrPol;
        end
    end

    // ----------------------------------------
    // phase state preload
    // ----------------------------------------
    // direct access loads now
    always_ff @(posedge clk) begin
        if (srst) begin
            phaseStatePre <= PHST_RST;
            outputState   <= PHST_RST;
        end else begin
            if (wrPh) phaseStatePre <= pwdata[5:0];
            if (wrPh && directAccess) begin
                outputState <= pwdata[5:0];
            end else if (commEvent && !directAccess) begin
                outputState <= phaseStatePre;
            end
        end
    end

    // ----------------------------------------
    // channel manager feed
    // ----------------------------------------
    // single phase forward, all three phases under pcn
    assign next_chanMgrPwm = channelCountSel ? {pwmW, pwmV, pwmU}
                                             : {2'b00, pwmU};

    // ----------------------------------------
    // chopper
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            chopCnt <= 10'h000;
        end else begin
            chopCnt <= chopCnt + 10'h001;
        end
    end
    wire [3:0] chopBit  = {1'b0, chopperFrequency} + 4'h2;
    wire       chopWave = chopCnt[chopBit];

    // ----------------------------------------
    // complementary drive
    // ----------------------------------------
    // needs clock and output enable
    wire enOn      = clockEnable & masterOutputEnable;
    wire pairedDac = directAccess & ~channelCountSel & deadtimeEnable;
    wire compOn    = channelCountSel | (directAccess & deadtimeEnable);
    wire [2:0] pwmSel = next_chanMgrPwm | {2'b00, 1'b0} |
                        (channelCountSel ? 3'b000 : {pwmU, pwmU, 1'b0});
    wire [2:0] pwmA   = pwmSel ^ {3{pwmApplicationSel & pairedDac}};
    wire chopHi = ~(pairedDac & chopperEnable[0]) | chopWave;
    wire chopLo = ~(pairedDac & chopperEnable[1]) | chopWave;
    logic [5:0] rawAct;
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            rawAct[2*p] = outputState[2*p] & pwmA[p] & chopHi;
            rawAct[2*p+1] = outputState[2*p+1] & chopLo &
                            (compOn ? ~pwmA[p] : pwmA[p]);
        end
    end

    assign outBus.act   = enOn ? rawAct : 6'h00;
    assign outBus.dtOn  = deadtimeEnable;
    assign outBus.dtCyc = ({4'h0, deadtimeSetting} + 10'h001) * DT_STEP_CYC;
    assign outBus.pol   = outputPolarity;

    // ----------------------------------------
    // submodules
    // ----------------------------------------
    dtp_deadtime uDeadtime (
        .clk  (clk),
        .srst (srst),
        .bus  (outBus)
    );

    dtp_stage uStage (
        .clk          (clk),
        .srst         (srst),
        .bus          (outBus),
        .motorOutPins (motorOutPins)
    );

    // ----------------------------------------
    // registered side outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            chanMgrPwm      <= 3'h0;
            motorOutEn      <= 1'b0;
            edgeRelationSel <= 1'b0;
            bemfChannelSel  <= 1'b0;
        end else begin
            chanMgrPwm      <= next_chanMgrPwm;
            motorOutEn      <= enOn;
            edgeRelationSel <= outputPolarityConfig[ZVD_BIT];
            bemfChannelSel  <= outputPolarityConfig[REO_BIT];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chan_single_a: assert property (
        !channelCountSel |=> chanMgrPwm == {2'b00, $past(pwmU)})
        else $error("single channel feed wrong");

    chan_three_a: assert property (
        channelCountSel |=> chanMgrPwm == $past({pwmW, pwmV, pwmU}))
        else $error("three channel feed wrong");

    dt_lock_a: assert property (
        wrDt && dtLocked |=> $stable(deadtimeSetting))
        else $error("deadtime setting rewritten");

    dte_once_a: assert property (
        wrDt && channelCountSel && dtLocked |=> $stable(deadtimeEnable))
        else $error("deadtime enable rewritten");

    reset_vals_a: assert property (
        $past(srst) |-> deadtimeConfig == DTCFG_RST
                        && outputPolarityConfig == POL_RST)
        else $error("reset value wrong");

    pol_lock_a: assert property (
        wrPol && polLocked |=> $stable(outputPolarity))
        else $error("polarity rewritten");

    direct_load_a: assert property (
        wrPh && directAccess |=> outputState == $past(pwdata[5:0]))
        else $error("direct load missed");

    out_gate_a: assert property (
        !enOn |=> ##[0:1] outBus.gated == 6'h00)
        else $error("outputs active while disabled");

    no_overlap_a: assert property (
        deadtimeEnable && $stable(deadtimeEnable)
        |-> !(outBus.gated[0] && outBus.gated[1]))
        else $error("pair overlap");

    pin_map_a: assert property (
        ##1 motorOutPins == ~($past(outputPolarity) ^ $past(outBus.gated)))
        else $error("pin level wrong");

    // ----------------------------------------
    // covers
    // ----------------------------------------
    three_ch_c: cover property (channelCountSel && enOn && deadtimeEnable);
    paired_c:   cover property (pairedDac && enOn && outBus.gated[1]);
    lock_c:     cover property (wrDt ##[1:20] wrDt);
    err_c:      cover property (pready && pslverr);

endmodule // dtp_top

// File: verif/dtp_stage_model.sv
// dtp_stage_model: inverter power stage fed by the six motor pins
// assumes pins from the block on clk, fixed active levels given as a parameter
`timescale 1ns/1ps
module dtp_stage_model #(
    parameter logic [5:0] ACTIVE_POL = 6'h00
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [5:0] motorOutPins,
    input  wire logic       motorOutEn,
    output int              overlaps
);
    logic [5:0] swOn;
    // ----------------------------------------
    // switch states
    // ----------------------------------------
    // pin level to switch
    assign swOn = ~(motorOutPins ^ ACTIVE_POL);
    always_ff @(posedge clk) begin
        if (srst) begin
            overlaps <= 0;
        end else if (motorOutEn && ((swOn[0] && swOn[1]) || (swOn[2] && swOn[3])
                     || (swOn[4] && swOn[5]))) begin
            overlaps <= overlaps + 1;
        end
    end
endmodule // dtp_stage_model

// File: verif/deadtime_and_output_polarity_bench.sv
// deadtime_and_output_polarity_bench: self-checking bench of dtp_top
// assumes apb master and pwm sources on one 100 MHz clock
`timescale 1ns/1ps
module deadtime_and_output_polarity_bench;
    import dtp_pkg::*;
    logic        clk, srst, psel, penable, pwrite, pwmU, pwmV, pwmW, commEvent;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, motorOutEn, edgeRelationSel, bemfChannelSel, er;
    logic [2:0]  chanMgrPwm;
    logic [5:0]  motorOutPins;
    int          fails, comparisons, overlaps;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} dtp_row_t;
    dtp_row_t rows[7] = '{
        '{1'b1, 8'h00, 32'h81, 32'h81, 1'b0},
        '{1'b1, 8'h00, 32'hC5, 32'h81, 1'b0},
        '{1'b1, 8'h00, 32'h41, 32'h01, 1'b0},
        '{1'b1, 8'h00, 32'h4F, 32'h41, 1'b0},
        '{1'b1, 8'h04, 32'hC0, 32'hC0, 1'b0},
        '{1'b1, 8'h04, 32'h3F, 32'h00, 1'b0},
        '{1'b1, 8'h14, 32'h55, 32'h00, 1'b1}};
    dtp_top i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwmU(pwmU), .pwmV(pwmV), .pwmW(pwmW), .commEvent(commEvent),
        .chanMgrPwm(chanMgrPwm), .motorOutPins(motorOutPins), .motorOutEn(motorOutEn),
        .edgeRelationSel(edgeRelationSel), .bemfChannelSel(bemfChannelSel));
    dtp_stage_model #(.ACTIVE_POL(6'h00)) i_stage (.clk(clk), .srst(srst),
        .motorOutPins(motorOutPins), .motorOutEn(motorOutEn), .overlaps(overlaps));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chkReg(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic chkPin(input string n, input logic [5:0] x, input logic [5:0] g);
        comparisons++;
        if (g !== x) begin
            fails++;
            $display("mismatch %s expected %b seen %b", n, x, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulseComm;
        @(posedge clk);
        commEvent <= 1'b1;
        @(posedge clk);
        commEvent <= 1'b0;
    endtask
    // ----------------------------------------
    // clock, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("mismatch watchdog expected finish seen timeout");
        finish_test;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, pwmU, pwmV, pwmW, commEvent} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        // polarity 1 state 0 is low
        chkPin("pins", 6'h00, motorOutPins);
        apb(1'b0, ADDR_DTCFG, 32'h0);
        chkReg("dtcfg", 32'hFF, rd);
        apb(1'b0, ADDR_POLCFG, 32'h0);
        chkReg("polcfg", 32'h3F, rd);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chkReg("wr err", {31'h0, rows[i].e}, {31'h0, er});
            apb(1'b0, rows[i].a, 32'h0);
            chkReg("rdata", rows[i].q, rd);
            chkReg("rd err", {31'h0, rows[i].e}, {31'h0, er});
            if (i == 4) begin
                chkPin("sides", 6'h03, {4'h0, edgeRelationSel, bemfChannelSel});
            end
        end
        chkPin("sides", 6'h00, {4'h0, edgeRelationSel, bemfChannelSel});
        // paired direct access, both sides wait the 26 cycle deadtime
        // polarity before enable
        apb(1'b1, ADDR_CTRL, 32'h007);
        apb(1'b1, ADDR_PHST, 32'h03);
        repeat (32) @(posedge clk);
        chkPin("motorOutEn", 6'h01, {5'h0, motorOutEn});
        chkPin("pins low on", 6'h3D, motorOutPins);
        pwmU <= 1'b1;
        pwmV <= 1'b1;
        pwmW <= 1'b1;
        repeat (10) @(posedge clk);
        chkPin("pins gap", 6'h3F, motorOutPins);
        repeat (30) @(posedge clk);
        chkPin("pins high on", 6'h3E, motorOutPins);
        chkPin("chan", 6'h01, {3'h0, chanMgrPwm});
        apb(1'b1, ADDR_CTRL, 32'h003);
        apb(1'b1, ADDR_DTCFG, 32'h80);
        apb(1'b0, ADDR_DTCFG, 32'h0);
        chkReg("dtcfg", 32'h81, rd);
        repeat (3) @(posedge clk);
        chkPin("chan", 6'h07, {3'h0, chanMgrPwm});
        // phase state loads on commutation when not direct
        apb(1'b1, ADDR_PHST, 32'h01);
        apb(1'b0, ADDR_PHST, 32'h0);
        chkReg("phst", 32'h03, rd);
        pulseComm;
        apb(1'b0, ADDR_PHST, 32'h0);
        chkReg("phst", 32'h01, rd);
        apb(1'b1, ADDR_PHST, 32'h03);
        pulseComm;
        for (int k = 0; k < 2; k++) begin
            pwmU <= k[0];
            repeat (4) @(posedge clk);
            chkPin("pins compl", k[0] ? 6'h3E : 6'h3D, motorOutPins);
        end
        apb(1'b1, ADDR_CTRL, 32'h001);
        repeat (4) @(posedge clk);
        chkPin("motorOutEn", 6'h00, {5'h0, motorOutEn});
        chkPin("pins off", 6'h3F, motorOutPins);
        chkReg("overlaps", 32'h0, overlaps);
        {pwmU, pwmV, pwmW} <= 3'b000;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        apb(1'b0, ADDR_DTCFG, 32'h0);
        chkReg("dtcfg rst", 32'hFF, rd);
        apb(1'b1, ADDR_DTCFG, 32'h40);
        apb(1'b0, ADDR_DTCFG, 32'h0);
        chkReg("dtcfg relock", 32'h40, rd);
        apb(1'b1, ADDR_POLCFG, 32'h00);
        apb(1'b1, ADDR_CTRL, 32'h00F);
        apb(1'b1, ADDR_PHST, 32'h01);
        repeat (20) @(posedge clk);
        chkPin("pins appl sel", 6'h3E, motorOutPins);
        finish_test;
    end
endmodule // deadtime_and_output_polarity_bench
